// *** verilog/pwm_timer_pkg.sv ***
// Package with register map, field layouts, reset values and carrier types of the PWM timer.
package pwm_timer_pkg;
  localparam logic [7:0] OFFSET_CTRL1 = 8'h00;
  localparam logic [7:0] OFFSET_CTRL2 = 8'h04;
  localparam logic [7:0] OFFSET_STATUS = 8'h08;
  localparam logic [7:0] OFFSET_PULSE_HIGH = 8'h0C;
  localparam logic [7:0] OFFSET_PULSE_LOW = 8'h10;
  localparam logic [7:0] OFFSET_PERIOD_HIGH = 8'h14;
  localparam logic [7:0] OFFSET_PERIOD_LOW = 8'h18;
  localparam logic [7:0] OFFSET_COUNTER = 8'h1C;
  localparam logic [7:0] OFFSET_CAPTURE1 = 8'h20;
  localparam logic [7:0] OFFSET_CAPTURE2 = 8'h24;

  localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
  localparam logic [15:0] COUNTER_RELOAD = 16'hFFFC;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  localparam logic [1:0] CLOCK_DIV4 = 2'h0;
  localparam logic [1:0] CLOCK_DIV2 = 2'h1;
  localparam logic [1:0] CLOCK_DIV8 = 2'h2;
  localparam logic [1:0] CLOCK_EXTERNAL = 2'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  localparam int STATUS_FIRST_CAPTURE = 7;
  localparam int STATUS_FIRST_MATCH = 6;
  localparam int STATUS_OVERFLOW = 5;
  localparam int STATUS_SECOND_CAPTURE = 4;
  localparam int STATUS_SECOND_MATCH = 3;

  // Control word 1, bit 7 down to bit 0.
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_second;
    logic force_first;
    logic level_after_second_match;
    logic first_capture_edge;
    logic level_after_first_match;
  } ctrl1_t;

  // Control word 2, bit 7 down to bit 0.
  typedef struct packed {
    logic wave_pin_enable;
    logic second_pin_enable;
    logic single_pulse_mode;
    logic pwm_enable;
    logic [1:0] timer_clock_select;
    logic second_capture_edge;
    logic external_edge;
  } ctrl2_t;

  // Sticky event flags.
  typedef struct packed {
    logic first_capture_flag;
    logic first_match_flag;
    logic overflow_flag;
    logic second_capture_flag;
    logic second_match_flag;
  } flags_t;
endpackage

// *** verilog/timer_tick_gen.sv ***
// Timer tick generator: divides the system clock or follows the external clock edge.
`timescale 1ns/1ps
module timer_tick_gen
  import pwm_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] timer_clock_select,
  input wire logic external_edge,
  input wire logic ext_clk,
  input wire logic freeze,
  output logic tick
);
  logic [2:0] div_count;
  logic [2:0] next_div_count;
  logic ext_prev;
  logic [2:0] last_count;

  always_comb
  begin
    unique case (timer_clock_select)
      CLOCK_DIV2: last_count = DIV2_LAST;
      CLOCK_DIV8: last_count = DIV8_LAST;
      default: last_count = DIV4_LAST;
    endcase
    next_div_count = div_count;
    tick = 1'b0;
    if (!freeze)
    begin
      if (timer_clock_select == CLOCK_EXTERNAL)
      begin
        tick = (ext_clk != ext_prev) && (ext_clk == external_edge);
        next_div_count = 3'h0;
      end
      else if (div_count >= last_count)
      begin
        tick = 1'b1;
        next_div_count = 3'h0;
      end
      else
      begin
        next_div_count = div_count + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      div_count <= 3'h0;
      ext_prev <= 1'b0;
    end
    else
    begin
      div_count <= next_div_count;
      ext_prev <= ext_clk;
    end
  end
endmodule

// *** verilog/pwm_timer.sv ***
// Sixteen-bit timer with PWM mode, output compare, input capture and low power behaviour.
// Functional notes
// - PWM output cycles with period from period compare, pulse from pulse compare.
// - Both compare values double buffered in PWM; new values load at period match.
// - Pulse match drives first level bit; period match drives second level bit.
// - First level 1, second 0: high pulse lasts period minus pulse value.
// - Equal level bits give a constant level on the wave pin.
// - Period match in PWM reloads the counter with FFFCh.
// - High byte write suspends that compare until its low byte is written.
// - PWM mode never sets either compare match flag.
// - In PWM, period match sets first capture flag, interrupting if enabled.
// - PWM disconnects first capture pin; second capture pin keeps working.
// - PWM and single pulse bits both set: only PWM acts.
// - PWM owns first compare and period compare; no other compare use.
// - Timer runs in Wait; enabled timer interrupt wakes from Wait.
// - Halt freezes counter and registers; interrupt wake resumes held count.
// - Capture edge in Halt arms; interrupt wake sets flag, stores exit count.
// - All events share one interrupt, gated by enable and global mask.
// - Capture, compare, overflow enables gate their flags; wake Wait, not Halt.
// - In PWM, second level goes to wave pin; single pulse holds wave pin at period match.
// - PWM bit set makes wave pin cyclic; clear leaves PWM inactive.
`timescale 1ns/1ps
module pwm_timer
  import pwm_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk,
  input wire logic first_capture_pin,
  input wire logic second_capture_pin,
  input wire logic global_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic halt_interrupt_wake,
  output logic wave_output_pin,
  output logic wave_pin_oe,
  output logic second_compare_pin,
  output logic second_compare_oe,
  output logic timer_irq,
  output logic wait_wakeup
);
  ctrl1_t ctrl1;
  ctrl1_t next_ctrl1;
  ctrl2_t ctrl2;
  ctrl2_t next_ctrl2;
  flags_t flags;
  flags_t next_flags;
  flags_t clear_armed;
  flags_t next_clear_armed;
  logic [15:0] counter;
  logic [15:0] next_counter;
  logic [15:0] pulse_compare_value;
  logic [15:0] next_pulse_compare_value;
  logic [15:0] period_compare_value;
  logic [15:0] next_period_compare_value;
  logic [15:0] active_pulse;
  logic [15:0] next_active_pulse;
  logic [15:0] active_period;
  logic [15:0] next_active_period;
  logic [15:0] first_capture_value;
  logic [15:0] next_first_capture_value;
  logic [15:0] second_capture_value;
  logic [15:0] next_second_capture_value;
  logic pulse_suspended;
  logic next_pulse_suspended;
  logic period_suspended;
  logic next_period_suspended;
  logic wave_level;
  logic next_wave_level;
  logic second_level;
  logic next_second_level;
  logic first_cap_prev;
  logic second_cap_prev;
  logic first_armed;
  logic next_first_armed;
  logic second_armed;
  logic next_second_armed;
  logic halt_prev;
  logic [31:0] next_prdata;
  logic tick;
  logic pwm_active;
  logic single_pulse_active;
  logic wr_en;
  logic rd_en;
  logic pulse_match;
  logic period_match;
  logic first_edge;
  logic second_edge;
  logic halt_exit;
  logic any_request;

  function automatic logic edge_seen(input logic now, input logic prev, input logic rising);
    edge_seen = (now != prev) && (now == rising);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    unique case (addr)
      OFFSET_CTRL1, OFFSET_CTRL2, OFFSET_STATUS, OFFSET_PULSE_HIGH, OFFSET_PULSE_LOW,
      OFFSET_PERIOD_HIGH, OFFSET_PERIOD_LOW, OFFSET_COUNTER, OFFSET_CAPTURE1,
      OFFSET_CAPTURE2: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  timer_tick_gen tick_gen (
    .clk_sys(clk_sys),
    .reset(reset),
    .timer_clock_select(ctrl2.timer_clock_select),
    .external_edge(ctrl2.external_edge),
    .ext_clk(ext_clk),
    .freeze(halt_mode),
    .tick(tick)
  );

  // Bus handshake and decode.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_en = psel && penable && pwrite && addr_mapped(paddr) && !halt_mode;
  assign rd_en = psel && penable && !pwrite && addr_mapped(paddr);

  assign pwm_active = ctrl2.pwm_enable;
  assign single_pulse_active = ctrl2.single_pulse_mode && !ctrl2.pwm_enable;
  assign pulse_match = tick && !pulse_suspended && (counter == active_pulse);
  assign period_match = tick && !period_suspended && (counter == active_period);
  assign first_edge = edge_seen(first_capture_pin, first_cap_prev, ctrl1.first_capture_edge);
  assign second_edge = edge_seen(second_capture_pin, second_cap_prev, ctrl2.second_capture_edge);
  assign halt_exit = halt_prev && !halt_mode && halt_interrupt_wake;

  // Shared interrupt request; the same request wakes from Wait, never from Halt.
  always_comb
  begin
    any_request = (ctrl1.capture_irq_enable && (flags.first_capture_flag || flags.second_capture_flag))
      || (ctrl1.compare_irq_enable && (flags.first_match_flag || flags.second_match_flag))
      || (ctrl1.overflow_irq_enable && flags.overflow_flag);
    timer_irq = any_request && !global_mask;
    wait_wakeup = wait_mode && !halt_mode && timer_irq;
  end

  assign wave_output_pin = wave_level;
  assign wave_pin_oe = ctrl2.wave_pin_enable;
  assign second_compare_pin = second_level;
  assign second_compare_oe = ctrl2.second_pin_enable && !pwm_active && !single_pulse_active;

  // Register writes, compare buffering and read data.
  always_comb
  begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_pulse_compare_value = pulse_compare_value;
    next_period_compare_value = period_compare_value;
    next_pulse_suspended = pulse_suspended;
    next_period_suspended = period_suspended;
    next_prdata = prdata;
    if (wr_en)
    begin
      unique case (paddr)
        OFFSET_CTRL1: next_ctrl1 = ctrl1_t'(pwdata[7:0]);
        OFFSET_CTRL2: next_ctrl2 = ctrl2_t'(pwdata[7:0]);
        OFFSET_PULSE_HIGH:
        begin
          next_pulse_compare_value[15:8] = pwdata[7:0];
          next_pulse_suspended = 1'b1;
        end
        OFFSET_PULSE_LOW:
        begin
          next_pulse_compare_value[7:0] = pwdata[7:0];
          next_pulse_suspended = 1'b0;
        end
        OFFSET_PERIOD_HIGH:
        begin
          next_period_compare_value[15:8] = pwdata[7:0];
          next_period_suspended = 1'b1;
        end
        OFFSET_PERIOD_LOW:
        begin
          next_period_compare_value[7:0] = pwdata[7:0];
          next_period_suspended = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFFSET_CTRL1: next_prdata = {24'h000000, ctrl1};
        OFFSET_CTRL2: next_prdata = {24'h000000, ctrl2};
        OFFSET_STATUS: next_prdata = {24'h000000, flags, 3'h0};
        OFFSET_PULSE_HIGH: next_prdata = {24'h000000, pulse_compare_value[15:8]};
        OFFSET_PULSE_LOW: next_prdata = {24'h000000, pulse_compare_value[7:0]};
        OFFSET_PERIOD_HIGH: next_prdata = {24'h000000, period_compare_value[15:8]};
        OFFSET_PERIOD_LOW: next_prdata = {24'h000000, period_compare_value[7:0]};
        OFFSET_COUNTER: next_prdata = {16'h0000, counter};
        OFFSET_CAPTURE1: next_prdata = {16'h0000, first_capture_value};
        OFFSET_CAPTURE2: next_prdata = {16'h0000, second_capture_value};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Counter, compare, capture and wave pin behaviour.
  always_comb
  begin
    next_counter = counter;
    next_active_pulse = active_pulse;
    next_active_period = active_period;
    next_wave_level = wave_level;
    next_second_level = second_level;
    next_flags = flags;
    next_clear_armed = clear_armed;
    next_first_capture_value = first_capture_value;
    next_second_capture_value = second_capture_value;
    next_first_armed = first_armed;
    next_second_armed = second_armed;
    // Outside PWM the compare values act at once; in PWM they wait for the period end.
    if (!pwm_active)
    begin
      next_active_pulse = pulse_compare_value;
      next_active_period = period_compare_value;
    end
    // Status read starts the two-step clear of the flags that are set.
    if (rd_en && (paddr == OFFSET_STATUS))
    begin
      next_clear_armed = flags;
    end
    if ((psel && penable && !halt_mode) && clear_armed.first_capture_flag && (paddr == OFFSET_CAPTURE1))
    begin
      next_flags.first_capture_flag = 1'b0;
      next_clear_armed.first_capture_flag = 1'b0;
    end
    if ((psel && penable && !halt_mode) && clear_armed.second_capture_flag && (paddr == OFFSET_CAPTURE2))
    begin
      next_flags.second_capture_flag = 1'b0;
      next_clear_armed.second_capture_flag = 1'b0;
    end
    if ((psel && penable && !halt_mode) && clear_armed.first_match_flag && (paddr == OFFSET_PULSE_LOW))
    begin
      next_flags.first_match_flag = 1'b0;
      next_clear_armed.first_match_flag = 1'b0;
    end
    if ((psel && penable && !halt_mode) && clear_armed.second_match_flag && (paddr == OFFSET_PERIOD_LOW))
    begin
      next_flags.second_match_flag = 1'b0;
      next_clear_armed.second_match_flag = 1'b0;
    end
    if ((psel && penable && !halt_mode) && clear_armed.overflow_flag && (paddr == OFFSET_COUNTER))
    begin
      next_flags.overflow_flag = 1'b0;
      next_clear_armed.overflow_flag = 1'b0;
    end
    if (halt_mode)
    begin
      // Counter and registers hold; capture edges only arm.
      if (first_edge && !pwm_active && !single_pulse_active)
      begin
        next_first_armed = 1'b1;
      end
      if (second_edge)
      begin
        next_second_armed = 1'b1;
      end
    end
    else
    begin
      if (tick)
      begin
        if (pwm_active && period_match)
        begin
          next_counter = COUNTER_RELOAD;
          next_wave_level = ctrl1.level_after_second_match;
          next_flags.first_capture_flag = 1'b1;
          next_active_pulse = pulse_compare_value;
          next_active_period = period_compare_value;
        end
        else
        begin
          next_counter = counter + 16'h0001;
          if (counter == COUNTER_MAX)
          begin
            next_flags.overflow_flag = 1'b1;
          end
        end
        if (pwm_active)
        begin
          if (pulse_match && !period_match)
          begin
            next_wave_level = ctrl1.level_after_first_match;
          end
        end
        else
        begin
          if (pulse_match)
          begin
            next_flags.first_match_flag = 1'b1;
            next_wave_level = ctrl1.level_after_first_match;
          end
          if (period_match)
          begin
            next_flags.second_match_flag = 1'b1;
            if (single_pulse_active)
            begin
              next_wave_level = wave_level;
            end
            else
            begin
              next_second_level = ctrl1.level_after_second_match;
            end
          end
        end
      end
      if (!pwm_active && !single_pulse_active)
      begin
        if (ctrl1.force_first)
        begin
          next_wave_level = ctrl1.level_after_first_match;
        end
        if (ctrl1.force_second)
        begin
          next_second_level = ctrl1.level_after_second_match;
        end
      end
      if (first_edge && !pwm_active && !single_pulse_active)
      begin
        next_flags.first_capture_flag = 1'b1;
        next_first_capture_value = counter;
      end
      if (second_edge)
      begin
        next_flags.second_capture_flag = 1'b1;
        next_second_capture_value = counter;
      end
      if (halt_exit && first_armed)
      begin
        next_flags.first_capture_flag = 1'b1;
        next_first_capture_value = counter;
      end
      if (halt_exit && second_armed)
      begin
        next_flags.second_capture_flag = 1'b1;
        next_second_capture_value = counter;
      end
      if (halt_prev)
      begin
        next_first_armed = 1'b0;
        next_second_armed = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl1 <= ctrl1_t'(CTRL1_RESET);
      ctrl2 <= ctrl2_t'(CTRL2_RESET);
      pulse_compare_value <= COMPARE_RESET;
      period_compare_value <= COMPARE_RESET;
      active_pulse <= COMPARE_RESET;
      active_period <= COMPARE_RESET;
      pulse_suspended <= 1'b0;
      period_suspended <= 1'b0;
      counter <= COUNTER_RESET;
      flags <= '0;
      clear_armed <= '0;
      first_capture_value <= 16'h0000;
      second_capture_value <= 16'h0000;
      wave_level <= 1'b0;
      second_level <= 1'b0;
      first_cap_prev <= 1'b0;
      second_cap_prev <= 1'b0;
      first_armed <= 1'b0;
      second_armed <= 1'b0;
      halt_prev <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      pulse_compare_value <= next_pulse_compare_value;
      period_compare_value <= next_period_compare_value;
      active_pulse <= next_active_pulse;
      active_period <= next_active_period;
      pulse_suspended <= next_pulse_suspended;
      period_suspended <= next_period_suspended;
      counter <= next_counter;
      flags <= next_flags;
      clear_armed <= next_clear_armed;
      first_capture_value <= next_first_capture_value;
      second_capture_value <= next_second_capture_value;
      wave_level <= next_wave_level;
      second_level <= next_second_level;
      first_cap_prev <= first_capture_pin;
      second_cap_prev <= second_capture_pin;
      first_armed <= next_first_armed;
      second_armed <= next_second_armed;
      halt_prev <= halt_mode;
      prdata <= next_prdata;
    end
  end
endmodule

// *** testbench/pwm_timer_monitor.sv ***
// Checker of the PWM timer port behaviour, bound to the timer.
`timescale 1ns/1ps
module pwm_timer_monitor
  import pwm_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic wave_output_pin,
  input wire logic wave_pin_oe,
  input wire logic timer_irq,
  input wire logic wait_wakeup
);
  wire logic unmapped = (paddr > OFFSET_CAPTURE2) || (paddr[1:0] != 2'h0);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_zero_wait_answer: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase without ready");
  a_unmapped_error: assert property (psel && penable && unmapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (psel && penable && !unmapped |-> !pslverr)
    else $error("error on mapped access");
  a_irq_masked: assert property (global_mask |-> !timer_irq)
    else $error("interrupt while masked");
  a_wait_wakes: assert property (wait_mode && !halt_mode && timer_irq |-> wait_wakeup)
    else $error("no wake from wait");
  a_halt_no_wake: assert property (halt_mode |-> !wait_wakeup)
    else $error("wait wake during halt");
  a_halt_wave_held: assert property (halt_mode ##1 halt_mode |=> $stable(wave_output_pin))
    else $error("wave moved during halt");
  a_halt_regs_held: assert property ($past(halt_mode) && halt_mode |-> $stable(wave_pin_oe))
    else $error("enable moved during halt");
  a_reset_quiet: assert property ($fell(reset) |-> !wave_output_pin && !timer_irq && !wave_pin_oe)
    else $error("outputs active after reset");
  c_wait_wake: cover property (wait_wakeup);
  c_refused: cover property (psel && penable && pslverr);
  c_wave_rise: cover property ($rose(wave_output_pin));
  c_halt_exit: cover property (halt_mode ##1 !halt_mode);
endmodule
bind pwm_timer pwm_timer_monitor mon (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_mask(global_mask), .wait_mode(wait_mode), .halt_mode(halt_mode), .wave_output_pin(wave_output_pin),
  .wave_pin_oe(wave_pin_oe), .timer_irq(timer_irq), .wait_wakeup(wait_wakeup));

// *** testbench/pwm_load_model.sv ***
// Model of the load circuit: capture sources, still external clock and pulse measurement.
`timescale 1ns/1ps
module pwm_load_model
(
  input wire logic clk_sys,
  input wire logic wave_output_pin,
  input wire logic wave_pin_oe,
  input wire logic edge_req,
  output logic first_capture_pin,
  output logic second_capture_pin,
  output logic ext_clk,
  output int high_len,
  output int low_len
);
  logic level;
  logic last = 1'b0;
  int run = 0;
  // The pin has a pull-down, so a released pin reads low.
  assign level = wave_pin_oe ? wave_output_pin : 1'b0;
  // The external clock stands still, so selecting it holds the counter.
  assign ext_clk = 1'b0;
  initial
  begin
    first_capture_pin = 1'b0;
    second_capture_pin = 1'b0;
    high_len = 0;
    low_len = 0;
  end
  always @(posedge clk_sys)
  begin
    first_capture_pin <= edge_req;
    second_capture_pin <= edge_req;
  end
  // Run lengths are measured on the falling edge, away from output updates.
  always @(negedge clk_sys)
  begin
    last <= level;
    if (level != last)
    begin
      if (last)
        high_len <= run;
      else
        low_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
  end
endmodule

// *** testbench/timer_pwm_mode_and_wakeup_tb.sv ***
// Self-checking testbench of the PWM timer over its APB registers.
`timescale 1ns/1ps
module timer_pwm_mode_and_wakeup_tb
  import pwm_timer_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clk, cap1, cap2, edge_req = 1'b0;
  logic global_mask = 1'b1;
  logic wait_mode = 1'b0;
  logic halt_mode = 1'b0;
  logic halt_wake = 1'b0;
  logic wave, wave_oe, pin2, pin2_oe, irq, wake;
  logic [31:0] rd, c1;
  int high_len, low_len, errors = 0, n_checks = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  pwm_timer dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
    .first_capture_pin(cap1), .second_capture_pin(cap2), .global_mask(global_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .halt_interrupt_wake(halt_wake), .wave_output_pin(wave), .wave_pin_oe(wave_oe),
    .second_compare_pin(pin2), .second_compare_oe(pin2_oe), .timer_irq(irq), .wait_wakeup(wake));
  pwm_load_model load (.clk_sys(clk_sys), .wave_output_pin(wave), .wave_pin_oe(wave_oe), .edge_req(edge_req),
    .first_capture_pin(cap1), .second_capture_pin(cap2), .ext_clk(ext_clk), .high_len(high_len),
    .low_len(low_len));
  task test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd);
    check(rd & mask, exp);
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(OFFSET_CTRL2, 32'hFF, {24'h0, CTRL2_RESET});
    rd_chk(OFFSET_PULSE_HIGH, 32'hFF, {24'h0, COMPARE_RESET[15:8]});
    rd_chk(OFFSET_PERIOD_LOW, 32'hFF, {24'h0, COMPARE_RESET[7:0]});
    rd_chk(8'h30, 32'hFFFFFFFF, 32'h0);
    // Period first, then pulse, then levels, pin and mode, clock last.
    wr(OFFSET_PERIOD_HIGH, 8'h00);
    wr(OFFSET_PERIOD_LOW, 8'h10);
    wr(OFFSET_PULSE_HIGH, 8'h00);
    wr(OFFSET_PULSE_LOW, 8'h08);
    wr(OFFSET_CTRL1, 8'h81);
    wr(OFFSET_CTRL2, 8'hFE);
    wr(OFFSET_CTRL2, 8'hF6);
    repeat (150) @(posedge clk_sys);
    check(32'(high_len), 32'h10);
    check(32'(low_len), 32'h1A);
    check(32'(high_len + low_len), 32'h2A);
    check({30'h0, wave_oe, pin2_oe}, 32'h2);
    wr(OFFSET_PULSE_HIGH, 8'h00);
    wr(OFFSET_PULSE_LOW, 8'h0C);
    repeat (150) @(posedge clk_sys);
    check(32'(high_len), 32'h08);
    check(32'(low_len), 32'h22);
    rd_chk(OFFSET_STATUS, 32'hC8, 32'h80);
    check({31'h0, irq}, 32'h0);
    global_mask <= 1'b0;
    wait_mode <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({30'h0, irq, wake}, 32'h3);
    @(posedge clk_sys);
    halt_mode <= 1'b1;
    halt_wake <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, wake}, 32'h0);
    apb(1'b0, OFFSET_COUNTER, 32'h0, c1);
    edge_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd_chk(OFFSET_COUNTER, 32'hFFFFFFFF, c1);
    halt_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    halt_wake <= 1'b0;
    wait_mode <= 1'b0;
    rd_chk(OFFSET_STATUS, 32'h10, 32'h10);
    rd_chk(OFFSET_CAPTURE2, 32'hFFFFFFFF, c1);
    edge_req <= 1'b0;
    wr(OFFSET_CTRL1, 8'h05);
    repeat (60) @(posedge clk_sys);
    repeat (4)
    begin
      repeat (11) @(negedge clk_sys);
      check({31'h0, wave}, 32'h1);
    end
    // Outside PWM the second compare pin is driven and takes its forced level.
    wr(OFFSET_CTRL2, 8'h46);
    wr(OFFSET_CTRL1, 8'h14);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({29'h0, wave_oe, pin2_oe, pin2}, 32'h3);
    test_done();
  end
endmodule
